// >>> common/cq_port_pkg.sv
package cq_port_pkg;

   // Widths of the delivery port.
   localparam int MAX_WIDTH      = 256;
   localparam int MAX_DWORDS     = 8;
   localparam int MAX_BYTES      = 32;
   localparam int SIDEBAND_WIDTH = 85;
   localparam int CREDIT_WIDTH   = 6;
   localparam logic [5:0] CREDIT_MAX = 6'h20;

   // Register map, byte addresses of 32-bit words.
   localparam logic [7:0] CTRL_OFFSET      = 8'h00;
   localparam logic [7:0] STATUS_OFFSET    = 8'h04;
   localparam logic [7:0] POSTED_CNT_OFFSET = 8'h08;
   localparam logic [7:0] NP_CNT_OFFSET    = 8'h0c;

   // Control register fields and reset value.
   localparam int CTRL_ENABLE_BIT        = 0;
   localparam int CTRL_POSTED_FIRST_BIT  = 1;
   localparam logic [1:0] CTRL_RESET     = 2'h3;

   // Status register fields.
   localparam int STATUS_CREDIT_LSB  = 0;
   localparam int STATUS_BUSY_BIT    = 8;
   localparam int STATUS_NP_BIT      = 9;

   localparam logic [3:0] MASK_ALL_ONES = 4'hf;

   // One beat offered by an internal request queue.
   typedef struct packed {
      logic [255:0] data;
      logic [3:0]   dword_count;
      logic [31:0]  byte_valid;
      logic [3:0]   first_mask;
      logic [3:0]   last_mask;
      logic         mask_force;
      logic         zero_length;
      logic         has_payload;
      logic         read_error;
      logic         last;
   } req_beat_t;

   // Sideband vector as seen by the client, bit 0 at the bottom.
   typedef struct packed {
      logic [31:0] parity;
      logic [10:0] hint;
      logic        read_error;
      logic        start;
      logic [31:0] byte_valid;
      logic [3:0]  last_mask;
      logic [3:0]  first_mask;
   } sideband_t;

   typedef enum logic [1:0] {
      ARB_IDLE,
      ARB_POSTED,
      ARB_NONPOSTED
   } arb_state_t;

endpackage : cq_port_pkg

// >>> core/completer_request_stream_port.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Data width 64, 128 or 256 bits.
// - Unused upper data bits held zero.
// - 85-bit sideband valid only with valid.
// - End marker on each packet's final beat.
// - Contiguous dword valid bits, full except last.
// - Unused dword valid bits held zero.
// - Valid stays high through a whole packet.
// - Beat moves when valid and ready high.
// - Hold beat stable while ready is low.
// - Credit up per grant, down per non-posted packet.
// - Zero credit withholds non-posted, posted continue.
// - Six-bit credit level saturating at 32.
// - Credit level may lag the grant.
// - First dword mask, ones for forced cases.
// - Last dword mask, ones for forced cases.
// - Byte valid marks payload bytes only.
// - Byte valid contiguous beyond two dwords.
// - Zero-length write shows no valid bytes.
// - Unused byte valid bits held zero.
// - Start flag on each packet's first beat.
// - Read error only on payload last beat.
// - Odd parity per byte, unused zero.
module completer_request_stream_port #(
   parameter int DATA_WIDTH = 256
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire cq_port_pkg::req_beat_t posted_beat_i,
   input  wire logic                  posted_valid_i,
   output logic                       posted_ready_o,
   input  wire cq_port_pkg::req_beat_t nonposted_beat_i,
   input  wire logic                  nonposted_valid_i,
   output logic                       nonposted_ready_o,
   output logic [255:0]               request_stream_data_o,
   output logic [84:0]                request_stream_sideband_o,
   output logic                       request_stream_end_o,
   output logic [7:0]                 request_stream_dword_valid_o,
   output logic                       request_stream_valid_o,
   input  wire logic                  request_stream_ready_i,
   input  wire logic                  nonposted_credit_grant_i,
   output logic [5:0]                 nonposted_credit_level_o,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o
);

   localparam int DWORDS = DATA_WIDTH / 32;
   localparam int BYTES  = DATA_WIDTH / 8;

   if (DATA_WIDTH != 64 && DATA_WIDTH != 128 && DATA_WIDTH != 256) begin : g_bad
      $error("DATA_WIDTH must be 64, 128 or 256.");
   end

   function automatic logic [255:0] data_mask();
      logic [255:0] m;
      m = '0;
      for (int i = 0; i < 256; i++) begin
         m[i] = (i < DATA_WIDTH);
      end
      return m;
   endfunction : data_mask

   function automatic logic [31:0] byte_mask();
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 32; i++) begin
         m[i] = (i < BYTES);
      end
      return m;
   endfunction : byte_mask

   // Dword valid bits grow from bit 0, so a short last beat stays contiguous.
   function automatic logic [7:0] keep_of(input logic [3:0] n);
      logic [7:0] k;
      k = '0;
      for (int i = 0; i < 8; i++) begin
         k[i] = (4'(i) < n) && (i < DWORDS);
      end
      return k;
   endfunction : keep_of

   function automatic logic [31:0] parity_of(input logic [255:0] d);
      logic [31:0] p;
      p = '0;
      for (int i = 0; i < 32; i++) begin
         p[i] = (i < BYTES) ? ~(^d[8*i +: 8]) : 1'b0;
      end
      return p;
   endfunction : parity_of

   localparam logic [255:0] DATA_MASK = data_mask();
   localparam logic [31:0]  BYTE_MASK = byte_mask();

   logic [1:0]                ctrl;
   logic [5:0]                credit;
   logic [31:0]               posted_count;
   logic [31:0]               np_count;
   cq_port_pkg::arb_state_t   state;
   logic                      load;
   logic                      pick_np;
   logic                      pick_posted;
   logic                      take;
   logic                      np_start;
   cq_port_pkg::req_beat_t    beat;
   cq_port_pkg::sideband_t    next_sideband;
   logic                      credit_up;
   logic [5:0]                next_credit;
   logic                      wb_hit;

   assign load = !request_stream_valid_o || request_stream_ready_i;

   // Posted traffic never waits on credit, so a stalled non-posted
   // queue cannot block writes behind it.
   always_comb begin
      pick_np     = 1'b0;
      pick_posted = 1'b0;
      case (state)
         cq_port_pkg::ARB_POSTED: begin
            pick_posted = 1'b1;
         end
         cq_port_pkg::ARB_NONPOSTED: begin
            pick_np = 1'b1;
         end
         cq_port_pkg::ARB_IDLE: begin
            if (ctrl[cq_port_pkg::CTRL_ENABLE_BIT]) begin
               if (nonposted_valid_i && credit != 6'h00 &&
                   !(posted_valid_i &&
                     ctrl[cq_port_pkg::CTRL_POSTED_FIRST_BIT])) begin
                  pick_np = 1'b1;
               end else begin
                  pick_posted = posted_valid_i;
               end
            end
         end
         default: begin
            pick_np     = 1'b0;
            pick_posted = 1'b0;
         end
      endcase
   end

   assign beat = pick_np ? nonposted_beat_i : posted_beat_i;
   assign take = load && ((pick_np && nonposted_valid_i) ||
                          (pick_posted && posted_valid_i));
   assign np_start = take && pick_np && state == cq_port_pkg::ARB_IDLE;

   always_comb begin
      posted_ready_o    = load && pick_posted;
      nonposted_ready_o = load && pick_np;
   end

   // The queues hold whole packets, so valid has no gap mid-packet.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= cq_port_pkg::ARB_IDLE;
      end else if (take) begin
         if (beat.last) begin
            state <= cq_port_pkg::ARB_IDLE;
         end else begin
            state <= pick_np ? cq_port_pkg::ARB_NONPOSTED
                             : cq_port_pkg::ARB_POSTED;
         end
      end
   end

   always_comb begin
      next_sideband            = '0;
      next_sideband.first_mask = beat.mask_force ? cq_port_pkg::MASK_ALL_ONES
                                                 : beat.first_mask;
      next_sideband.last_mask  = beat.mask_force ? cq_port_pkg::MASK_ALL_ONES
                                                 : beat.last_mask;
      next_sideband.byte_valid = beat.zero_length ? 32'h0000_0000
                                                  : beat.byte_valid & BYTE_MASK;
      next_sideband.start      = state == cq_port_pkg::ARB_IDLE;
      next_sideband.read_error = beat.read_error && beat.last &&
                                 beat.has_payload;
      next_sideband.hint       = '0;
      next_sideband.parity     = parity_of(beat.data & DATA_MASK);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         request_stream_valid_o <= 1'b0;
      end else if (load) begin
         request_stream_valid_o <= take;
      end
   end

   // Beat registers only move when the slot is empty or drained.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         request_stream_data_o        <= '0;
         request_stream_sideband_o    <= '0;
         request_stream_end_o         <= 1'b0;
         request_stream_dword_valid_o <= '0;
      end else if (take) begin
         request_stream_data_o        <= beat.data & DATA_MASK;
         request_stream_sideband_o    <= next_sideband;
         request_stream_end_o         <= beat.last;
         request_stream_dword_valid_o <= keep_of(beat.dword_count);
      end
   end

   assign credit_up = nonposted_credit_grant_i &&
                      (credit != cq_port_pkg::CREDIT_MAX || np_start);

   always_comb begin
      next_credit = credit;
      if (credit_up && !np_start) begin
         next_credit = credit + 6'h01;
      end else if (!credit_up && np_start) begin
         next_credit = credit - 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         credit <= '0;
      end else begin
         credit <= next_credit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nonposted_credit_level_o <= '0;
      end else begin
         nonposted_credit_level_o <= credit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         posted_count <= '0;
         np_count     <= '0;
      end else if (take && state == cq_port_pkg::ARB_IDLE) begin
         if (pick_np) begin
            np_count <= np_count + 32'h0000_0001;
         end else begin
            posted_count <= posted_count + 32'h0000_0001;
         end
      end
   end

   // Classic Wishbone slave answering every access in one cycle.
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= cq_port_pkg::CTRL_RESET;
      end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_sel_i[0] &&
                   wb_adr_i == cq_port_pkg::CTRL_OFFSET) begin
         ctrl <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (wb_hit && !wb_we_i) begin
         case (wb_adr_i)
            cq_port_pkg::CTRL_OFFSET: begin
               wb_dat_o <= {30'h0, ctrl};
            end
            cq_port_pkg::STATUS_OFFSET: begin
               wb_dat_o <= {22'h0, state == cq_port_pkg::ARB_NONPOSTED,
                            state != cq_port_pkg::ARB_IDLE, 2'h0, credit};
            end
            cq_port_pkg::POSTED_CNT_OFFSET: begin
               wb_dat_o <= posted_count;
            end
            cq_port_pkg::NP_CNT_OFFSET: begin
               wb_dat_o <= np_count;
            end
            default: begin
               wb_dat_o <= 32'h0000_0000;
            end
         endcase
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

endmodule : completer_request_stream_port

`default_nettype wire

// >>> sim/client_model.sv
`timescale 1ns/1ps
`default_nettype none
module client_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   input  wire logic want_i,
   input  wire logic tie_i,
   output logic      ready_o,
   output logic      grant_o
);
   logic [2:0] phase;
   // A slow client stalls three cycles in eight, often in mid-packet.
   always_ff @(posedge clk_i) begin
      phase   <= rst_i ? 3'h0 : phase + 3'h1;
      ready_o <= !rst_i && (!slow_i || phase < 3'h5);
   end
   // One-cycle pulses unless tied high, so each pulse is exactly one credit.
   always_ff @(posedge clk_i) begin
      grant_o <= !rst_i && want_i && (tie_i || !grant_o);
   end
endmodule : client_model
`default_nettype wire

// >>> sim/completer_request_stream_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module completer_request_stream_port_props #(
   parameter int DATA_WIDTH = 256
) (
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic [255:0] request_stream_data_o,
   input wire logic [84:0]  request_stream_sideband_o,
   input wire logic         request_stream_end_o,
   input wire logic [7:0]   request_stream_dword_valid_o,
   input wire logic         request_stream_valid_o,
   input wire logic         request_stream_ready_i,
   input wire logic [5:0]   nonposted_credit_level_o
);
   localparam logic [7:0] FULL = 8'((1 << (DATA_WIDTH / 32)) - 1);
   wire logic         v  = request_stream_valid_o;
   wire logic         r  = request_stream_ready_i;
   wire logic [255:0] d  = request_stream_data_o;
   wire logic [84:0]  sb = request_stream_sideband_o;
   wire logic [7:0]   kv = request_stream_dword_valid_o;
   logic              in_pkt;
   logic [31:0]       odd;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // The start flag can only be judged against where the last packet ended.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_pkt <= 1'b0;
      end else if (v && r) begin
         in_pkt <= !request_stream_end_o;
      end
   end
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         odd[i] = (i < DATA_WIDTH / 8) && !(^d[8*i +: 8]);
      end
   end
   hold_beat_a: assert property (
      v && !r |=> v && $stable(sb) && $stable(d) && $stable(kv))
      else $error("stalled beat changed");
   whole_pkt_a: assert property (
      v && r && !request_stream_end_o |=> v)
      else $error("valid dropped inside a packet");
   data_upper_a: assert property (
      (d >> DATA_WIDTH) == 256'h0)
      else $error("unused data bits set");
   keep_shape_a: assert property (
      v |-> (kv & ~FULL) == 8'h0 && ((kv + 8'h1) & kv) == 8'h0
      && kv != 8'h0 && (request_stream_end_o || kv == FULL))
      else $error("dword valid malformed");
   start_flag_a: assert property (
      v |-> sb[40] == !in_pkt)
      else $error("start flag misplaced");
   err_last_a: assert property (
      v && sb[41] |-> request_stream_end_o)
      else $error("read error off the last beat");
   parity_odd_a: assert property (
      v |-> sb[84:53] == odd)
      else $error("parity wrong");
   bytes_unused_a: assert property (
      (sb[39:8] >> (DATA_WIDTH / 8)) == 32'h0)
      else $error("unused byte valid bits set");
   level_max_a: assert property (
      nonposted_credit_level_o <= 6'h20)
      else $error("credit level above ceiling");
   rst_clear_a: assert property (
      $fell(rst_i) |-> !v && nonposted_credit_level_o == 6'h0)
      else $error("reset left state behind");
endmodule : completer_request_stream_port_props
`default_nettype wire

// >>> sim/test_completer_request_stream_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_completer_request_stream_port;
   localparam int DW = 128;
   localparam logic [7:0]  KF = 8'((1 << (DW / 32)) - 1);
   localparam logic [31:0] BF = 32'((64'h1 << (DW / 8)) - 1);
   typedef logic [306:0] shot_t;
   logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, want = 1'b0, tie = 1'b0;
   cq_port_pkg::req_beat_t posted_beat_i = '0, nonposted_beat_i = '0;
   logic posted_valid_i = 1'b0, nonposted_valid_i = 1'b0;
   logic posted_ready_o, nonposted_ready_o, request_stream_end_o;
   logic request_stream_valid_o, request_stream_ready_i, wb_ack_o;
   logic nonposted_credit_grant_i;
   logic [255:0] request_stream_data_o;
   logic [84:0]  request_stream_sideband_o;
   logic [7:0]   request_stream_dword_valid_o, wb_adr_i = 8'h0;
   logic [5:0]   nonposted_credit_level_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0]   wb_sel_i = 4'h0;
   logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q;
   shot_t        exp_q[$];
   int miscompares = 0, compares = 0, seed = 15101;
   int credit = 0, lag = 0, np_in = 0, p_in = 0, np_pk = 0, p_pk = 0;
   always #2.5 clk_i = ~clk_i;
   completer_request_stream_port #(.DATA_WIDTH(DW))
      completer_request_stream_port_i (.*);
   client_model client_model_i (.clk_i, .rst_i, .slow_i(slow),
      .want_i(want), .tie_i(tie), .ready_o(request_stream_ready_i),
      .grant_o(nonposted_credit_grant_i));
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic cq_port_pkg::req_beat_t mk(input logic last);
      cq_port_pkg::req_beat_t b;
      b = '0;
      for (int i = 0; i < 8; i++) begin
         b.data[32*i +: 32] = 32'(xs());
      end
      b.dword_count = last ? 4'(1 + (xs() & 3)) : 4'(DW / 32);
      b.byte_valid = 32'(xs());
      {b.first_mask, b.last_mask} = 8'(xs());
      {b.mask_force, b.zero_length, b.has_payload, b.read_error} = 4'(xs());
      b.last = last;
      return b;
   endfunction : mk
   function automatic shot_t shape(input cq_port_pkg::req_beat_t b,
                                   input logic s);
      logic [7:0] m;
      m = b.mask_force ? 8'hff : {b.last_mask, b.first_mask};
      return {b.data & {DW{1'b1}}, b.last,
         8'((1 << b.dword_count) - 1) & KF,
         b.last && b.has_payload && b.read_error, s,
         b.zero_length ? 32'h0 : b.byte_valid & BF, s ? m : 8'h0};
   endfunction : shape
   task automatic chk(input shot_t got, input shot_t exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("Counts: %0d compares, %0d mismatches", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic hang();
      miscompares++;
      print_verdict();
   endtask : hang
   // Each source holds valid across a whole packet, beats back to back.
   task automatic send(input logic np, input int pk);
      int n, t;
      for (int k = 0; k < pk; k++) begin
         n = 1 + (xs() & 3);
         for (int i = 0; i < n; i++) begin
            if (np) nonposted_beat_i <= mk(i == n - 1);
            else posted_beat_i <= mk(i == n - 1);
            if (np) nonposted_valid_i <= 1'b1;
            else posted_valid_i <= 1'b1;
            t = 0;
            do begin
               @(negedge clk_i);
               t++;
            end while ((np ? nonposted_ready_o : posted_ready_o) !== 1'b1
                       && t < 900);
            if (t >= 900) hang();
            @(posedge clk_i);
         end
      end
      if (np) nonposted_valid_i <= 1'b0;
      else posted_valid_i <= 1'b0;
   endtask : send
   task automatic wbx(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
      int t;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
      {wb_adr_i, wb_dat_i} <= {a, d};
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (t >= 50) hang();
   endtask : wbx
   always @(posedge clk_i) begin
      if (!rst_i) begin
         chk(shot_t'(nonposted_credit_level_o), shot_t'(lag));
         lag = credit;
         if (nonposted_valid_i && nonposted_ready_o) begin
            exp_q.push_back(shape(nonposted_beat_i, np_in == 0));
            credit -= (np_in == 0);
            np_pk += (np_in == 0);
            np_in = !nonposted_beat_i.last;
         end
         if (posted_valid_i && posted_ready_o) begin
            exp_q.push_back(shape(posted_beat_i, p_in == 0));
            p_pk += (p_in == 0);
            p_in = !posted_beat_i.last;
         end
         credit += (nonposted_credit_grant_i && credit < 32);
         if (request_stream_valid_o && request_stream_ready_i) begin
            chk({request_stream_data_o, request_stream_end_o,
               request_stream_dword_valid_o, request_stream_sideband_o[41:8],
               request_stream_sideband_o[40] ?
               request_stream_sideband_o[7:0] : 8'h0}, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(shot_t'({request_stream_valid_o, nonposted_credit_level_o}), 0);
      wbx(1'b0, cq_port_pkg::CTRL_OFFSET, 32'h0);
      chk(shot_t'(q), shot_t'(cq_port_pkg::CTRL_RESET));
      wbx(1'b1, cq_port_pkg::CTRL_OFFSET, 32'h1);
      wbx(1'b0, cq_port_pkg::CTRL_OFFSET, 32'h0);
      chk(shot_t'(q), shot_t'(32'h1));
      wbx(1'b0, 8'h10, 32'h0);
      chk(shot_t'(q), 0);
      $display("test registers done");
      fork
         send(1'b1, 1);
         begin
            repeat (4) @(posedge clk_i);
            send(1'b0, 2);
            chk(shot_t'(np_pk), 0);
            want <= 1'b1;
            repeat (2) @(posedge clk_i);
            want <= 1'b0;
         end
      join
      $display("test starvation done");
      @(posedge clk_i);
      {tie, want} <= 2'b11;
      repeat (40) @(posedge clk_i);
      want <= 1'b0;
      @(negedge clk_i);
      chk(shot_t'(nonposted_credit_level_o), 6'h20);
      $display("test saturation done");
      for (int s = 0; s < 2; s++) begin
         if (s == 1) wbx(1'b1, cq_port_pkg::CTRL_OFFSET, 32'h3);
         @(posedge clk_i);
         slow <= (s == 0);
         fork
            send(1'b0, 5);
            send(1'b1, 5);
         join
         $display("test traffic %0d done", s);
      end
      for (int t = 0; exp_q.size() > 0; t++) begin
         if (t > 100) hang();
         @(posedge clk_i);
      end
      wbx(1'b0, cq_port_pkg::POSTED_CNT_OFFSET, 32'h0);
      chk(shot_t'(q), shot_t'(p_pk));
      wbx(1'b0, cq_port_pkg::NP_CNT_OFFSET, 32'h0);
      chk(shot_t'(q), shot_t'(np_pk));
      wbx(1'b0, cq_port_pkg::STATUS_OFFSET, 32'h0);
      chk(shot_t'(q), shot_t'(credit));
      print_verdict();
   end
endmodule : test_completer_request_stream_port
bind completer_request_stream_port completer_request_stream_port_props
   #(.DATA_WIDTH(DATA_WIDTH)) props_i (.*);
`default_nettype wire
